// ### core/hmr_defines.vh
// Constants for the host miscellaneous runtime register bank.
// Assumes inclusion by bare name from the bank's design file.
`ifndef HMR_DEFINES_VH
`define HMR_DEFINES_VH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define HMR_IDX_FORCE_CHG  8'h20
`define HMR_IDX_RATE_SHD   8'h21
`define HMR_IDX_FIFO1_SHD  8'h22
`define HMR_IDX_FIFO2_SHD  8'h23
`define HMR_IDX_DEV_OFF    8'h24
`define HMR_IDX_LED        8'h25
`define HMR_IDX_WAKE_KEY   8'h26
`define HMR_IDX_POK        8'h27

// ****************************************************************
// Reset values and writable masks.
// ****************************************************************
`define HMR_RST_DEV_OFF    8'h00
`define HMR_RST_LED        8'h00
`define HMR_RST_WAKE_KEY   8'h00
`define HMR_RST_POK        8'hF1
`define HMR_RST_SHADOW     8'h00
`define HMR_WMASK_DEV_OFF  8'hE9
`define HMR_WMASK_LED      8'h0F
`define HMR_WMASK_POK      8'hF3
`define HMR_WMASK_POK_LOCK 8'hF0

// ****************************************************************
// Field positions.
// ****************************************************************
`define HMR_FORCE_BIT      0
`define HMR_PARPORT_OFF    7
`define HMR_SERIAL1_OFF    6
`define HMR_SERIAL2_OFF    5
`define HMR_FLOPPY_OFF     3
`define HMR_PROTECT_OVR    0
`define HMR_LED_CODE_FETCH 3
`define HMR_LED_COLOR      2
`define HMR_POK_DELAY      0
`define HMR_POK_LOCK       1
`define HMR_BUS_RST_OUT2   7
`define HMR_BUS_RST_OUT1   6
`define HMR_BUS_RST_OUT3   5
`define HMR_BUS_RST_OUT4   4

// ****************************************************************
// LED_CONTROL patterns and timing.
// ****************************************************************
`define HMR_LED_OFF        2'h0
`define HMR_LED_BLINK      2'h1
`define HMR_LED_ON         2'h3
`define HMR_CLK_KHZ        10000
`define HMR_LED_HALF_MS    500
`define HMR_LED_HALF_CYC   (`HMR_LED_HALF_MS * `HMR_CLK_KHZ)
`define HMR_POK_DLY_CYC    1000

`endif

// ### core/hmr_regs.v
// Host miscellaneous runtime register bank behind an APB slave port.
// Assumes all inputs are synchronous to pclk; presetn is the system
// and standby power-on reset, the other resets are sampled levels.
//
// Operation
// - Writing one latches drive-0 disk-change force; writing zero never clears.
// - Head step or drive-0 select activity clears the force latch.
// - Disk-change to core is (select0 and force) or external input, active low.
// - Force latch resets on standby POR, main-supply reset and bus reset.
// - Index 21h reads back the last floppy data-rate write.
// - Index 22h mirrors serial port 1 FIFO control writes.
// - Index 23h mirrors serial port 2 FIFO control writes.
// - A set disable bit blocks its device whatever its valid bit.
// - Disable bits: parallel D7, serial1 D6, serial2 D5, floppy D3.
// - Core write-protect combines selects, forced protect, pin and override.
// - LED_CONTROL register writable only when LED_CONTROL off or system fully on.
// - Pattern 0 off, 1 blinks at 1 Hz half duty, 3 on.
// - Hardware updates the pattern from sleep states and power-good.
// - Color bit picks LED_CONTROL pin color depending on power state.
// - Code-fetch flag is read-write and cleared by main-supply reset.
// - Index 26h holds the wake key scan code.
// - Power-good delay bit selects delayed 3.3 V power-good output.
// - Lock bit freezes delay and lock bits until standby POR.
// - Bus reset enables force outputs low or buffer the bus reset.
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`include "hmr_defines.vh"

module hmr_regs #(
	parameter HALF_CYCLES = `HMR_LED_HALF_CYC,
	parameter POK_CYCLES  = `HMR_POK_DLY_CYC
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        vcc_rst_n,
	input  wire        bus_rst_n,
	input  wire        drive_sel0_n,
	input  wire        drive_sel1_n,
	input  wire        step_n,
	input  wire        disk_changed_in_n,
	input  wire        write_protect_n,
	input  wire        forced_protect,
	output reg         core_disk_changed_n,
	output reg         core_write_protect_n,
	input  wire        rate_wr,
	input  wire [7:0]  rate_wdata,
	input  wire        fifo1_wr,
	input  wire [7:0]  fifo1_wdata,
	input  wire        fifo2_wr,
	input  wire [7:0]  fifo2_wdata,
	input  wire        parport_valid,
	input  wire        serial1_valid,
	input  wire        serial2_valid,
	input  wire        floppy_valid,
	output reg         parport_access_en,
	output reg         serial1_access_en,
	output reg         serial2_access_en,
	output reg         floppy_access_en,
	input  wire        sleep_state3_n,
	input  wire        sleep_state5_n,
	input  wire        supply_power_ok,
	output reg         led_yellow_n,
	output reg         led_green_n,
	output reg  [7:0]  wake_key_code,
	output reg         pok_out_3v,
	output reg  [3:0]  bus_rst_out_n
);

// ****************************************************************
// Address decode.
// ****************************************************************

// Offsets are word aligned, so each index sits at four times itself.
function hmr_hit;
	input [7:0] a;
	begin
		hmr_hit = (a[1:0] == 2'h0) &&
			(a[7:2] >= `HMR_IDX_FORCE_CHG) &&
			(a[7:2] <= `HMR_IDX_POK);
	end
endfunction

function [7:0] hmr_idx;
	input [7:0] a;
	begin
		hmr_idx = {2'h0, a[7:2]};
	end
endfunction

// ****************************************************************
// Register state.
// ****************************************************************
reg        force_chg_drive0;
reg [7:0]  rate_shadow;
reg [7:0]  fifo1_shadow;
reg [7:0]  fifo2_shadow;
reg [7:0]  dev_off;
reg [7:0]  led_ctrl;
reg [7:0]  pok_ctrl;
reg        sel0_n_q;
reg [22:0] blink_cnt;
reg        blink_phase;
reg [15:0] pok_cnt;

wire wr_acc = psel && penable && pready && pwrite && pstrb[0] &&
	hmr_hit(paddr);
wire [7:0] widx = hmr_idx(paddr);
wire [7:0] wbyte = pwdata[7:0];
wire sys_on = sleep_state3_n && sleep_state5_n && supply_power_ok;
wire [1:0] led_pat = led_ctrl[1:0];
wire led_wr_ok = (led_pat == `HMR_LED_OFF) || sys_on;

// ****************************************************************
// APB slave: one wait-free access phase, answered from flops.
// ****************************************************************
reg [7:0] rd_byte;
always @* begin
	case (hmr_idx(paddr))
	`HMR_IDX_FORCE_CHG: rd_byte = {7'h00, force_chg_drive0};
	`HMR_IDX_RATE_SHD:  rd_byte = rate_shadow;
	`HMR_IDX_FIFO1_SHD: rd_byte = fifo1_shadow;
	`HMR_IDX_FIFO2_SHD: rd_byte = fifo2_shadow;
	`HMR_IDX_DEV_OFF:   rd_byte = dev_off;
	`HMR_IDX_LED:       rd_byte = led_ctrl;
	`HMR_IDX_WAKE_KEY:  rd_byte = wake_key_code;
	`HMR_IDX_POK:       rd_byte = pok_ctrl;
	default:            rd_byte = 8'h00;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready  <= 1'b0;
		pslverr <= 1'b0;
		prdata  <= 32'h00000000;
	end else begin
		pready  <= psel && !penable;
		if (psel && !penable) begin
			pslverr <= !hmr_hit(paddr);
			prdata  <= hmr_hit(paddr) ? {24'h000000, rd_byte} :
				32'h00000000;
		end else begin
			pslverr <= 1'b0;
		end
	end
end

// ****************************************************************
// Floppy disk-change force latch.
// ****************************************************************

// Clearing on the release of drive-0 select lets the forced change be
// seen for the whole selection instead of vanishing at once.
wire sel0_release = !sel0_n_q && drive_sel0_n;
wire force_set = wr_acc && (widx == `HMR_IDX_FORCE_CHG) &&
	wbyte[`HMR_FORCE_BIT];

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		force_chg_drive0 <= 1'b0;
		sel0_n_q         <= 1'b1;
	end else begin
		sel0_n_q <= drive_sel0_n;
		if (!vcc_rst_n || !bus_rst_n)
			force_chg_drive0 <= 1'b0;
		else if (force_set)
			force_chg_drive0 <= 1'b1;
		else if (!step_n || sel0_release)
			force_chg_drive0 <= 1'b0;
	end
end

// ****************************************************************
// Floppy core signal combination.
// ****************************************************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		core_disk_changed_n  <= 1'b1;
		core_write_protect_n <= 1'b1;
	end else begin
		core_disk_changed_n <= !((!drive_sel0_n && force_chg_drive0) ||
			!disk_changed_in_n);
		core_write_protect_n <= !((!drive_sel0_n && forced_protect) ||
			(!drive_sel1_n && forced_protect) || !write_protect_n ||
			dev_off[`HMR_PROTECT_OVR]);
	end
end

// ****************************************************************
// Shadows of write-only registers.
// ****************************************************************

// Only the peripheral write strobes load these; host writes never do.
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rate_shadow  <= `HMR_RST_SHADOW;
		fifo1_shadow <= `HMR_RST_SHADOW;
		fifo2_shadow <= `HMR_RST_SHADOW;
	end else begin
		if (rate_wr)
			rate_shadow <= rate_wdata;
		if (fifo1_wr)
			fifo1_shadow <= fifo1_wdata;
		if (fifo2_wr)
			fifo2_shadow <= fifo2_wdata;
	end
end

// ****************************************************************
// Logical device disable and wake key.
// ****************************************************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		dev_off       <= `HMR_RST_DEV_OFF;
		wake_key_code <= `HMR_RST_WAKE_KEY;
	end else if (wr_acc) begin
		if (widx == `HMR_IDX_DEV_OFF)
			dev_off <= wbyte & `HMR_WMASK_DEV_OFF;
		if (widx == `HMR_IDX_WAKE_KEY)
			wake_key_code <= wbyte;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		parport_access_en <= 1'b0;
		serial1_access_en <= 1'b0;
		serial2_access_en <= 1'b0;
		floppy_access_en  <= 1'b0;
	end else begin
		parport_access_en <= parport_valid &&
			!dev_off[`HMR_PARPORT_OFF];
		serial1_access_en <= serial1_valid &&
			!dev_off[`HMR_SERIAL1_OFF];
		serial2_access_en <= serial2_valid &&
			!dev_off[`HMR_SERIAL2_OFF];
		floppy_access_en  <= floppy_valid &&
			!dev_off[`HMR_FLOPPY_OFF];
	end
end

// ****************************************************************
// LED_CONTROL control register.
// ****************************************************************
reg [7:0] next_led_ctrl;
always @* begin
	next_led_ctrl = led_ctrl;
	if (wr_acc && (widx == `HMR_IDX_LED) && led_wr_ok)
		next_led_ctrl = wbyte & `HMR_WMASK_LED;
	if (!sleep_state5_n)
		next_led_ctrl[1:0] = `HMR_LED_OFF;
	else if (!sleep_state3_n || !supply_power_ok)
		next_led_ctrl[1:0] = `HMR_LED_BLINK;
	if (!vcc_rst_n)
		next_led_ctrl = `HMR_RST_LED;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		led_ctrl <= `HMR_RST_LED;
	else
		led_ctrl <= next_led_ctrl;
end

// ****************************************************************
// Blink divider: a one-cycle enable flips the phase each half second.
// ****************************************************************
wire half_tick = (blink_cnt == HALF_CYCLES - 1);

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		blink_cnt   <= 23'h000000;
		blink_phase <= 1'b0;
	end else if (led_pat != `HMR_LED_BLINK) begin
		blink_cnt   <= 23'h000000;
		blink_phase <= 1'b1;
	end else if (half_tick) begin
		blink_cnt   <= 23'h000000;
		blink_phase <= !blink_phase;
	end else begin
		blink_cnt <= blink_cnt + 23'h000001;
	end
end

// ****************************************************************
// LED_CONTROL pins.
// ****************************************************************

// Color ties green to a set bit while running, and reverses in sleep
// so a sleeping system shows the other color for the same setting.
reg led_lit;
reg pick_green;
always @* begin
	case (led_pat)
	`HMR_LED_BLINK: led_lit = blink_phase;
	`HMR_LED_ON:    led_lit = 1'b1;
	default:        led_lit = 1'b0;
	endcase
	pick_green = sys_on ? led_ctrl[`HMR_LED_COLOR] :
		!led_ctrl[`HMR_LED_COLOR];
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		led_yellow_n <= 1'b1;
		led_green_n  <= 1'b1;
	end else begin
		led_green_n  <= !(led_lit && pick_green);
		led_yellow_n <= !(led_lit && !pick_green);
	end
end

// ****************************************************************
// Power-good control.
// ****************************************************************
reg [7:0] next_pok_ctrl;
always @* begin
	next_pok_ctrl = pok_ctrl;
	if (wr_acc && (widx == `HMR_IDX_POK)) begin
		if (pok_ctrl[`HMR_POK_LOCK])
			next_pok_ctrl = (pok_ctrl & ~`HMR_WMASK_POK_LOCK) |
				(wbyte & `HMR_WMASK_POK_LOCK);
		else
			next_pok_ctrl = wbyte & `HMR_WMASK_POK;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		pok_ctrl <= `HMR_RST_POK;
	else
		pok_ctrl <= next_pok_ctrl;
end

// The output drops at once on loss of supply; only the rise is delayed.
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pok_cnt    <= 16'h0000;
		pok_out_3v <= 1'b0;
	end else if (!supply_power_ok) begin
		pok_cnt    <= 16'h0000;
		pok_out_3v <= 1'b0;
	end else if (!pok_ctrl[`HMR_POK_DELAY]) begin
		pok_out_3v <= 1'b1;
	end else if (pok_cnt == POK_CYCLES - 1) begin
		pok_out_3v <= 1'b1;
	end else begin
		pok_cnt <= pok_cnt + 16'h0001;
	end
end

// ****************************************************************
// Buffered bus reset outputs.
// ****************************************************************
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		bus_rst_out_n <= 4'h0;
	end else begin
		bus_rst_out_n[0] <= pok_ctrl[`HMR_BUS_RST_OUT1] && bus_rst_n;
		bus_rst_out_n[1] <= pok_ctrl[`HMR_BUS_RST_OUT2] && bus_rst_n;
		bus_rst_out_n[2] <= pok_ctrl[`HMR_BUS_RST_OUT3] && bus_rst_n;
		bus_rst_out_n[3] <= pok_ctrl[`HMR_BUS_RST_OUT4] &&
			bus_rst_n;
	end
end

endmodule // hmr_regs

// ### test/hmr_regs_sva.sv
// Port checker for the runtime register bank, bound into hmr_regs.
// Assumes pclk is the only clock and presetn the only reset.
`timescale 1ns/10ps

module hmr_regs_sva (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [3:0]  pstrb,
	input wire        pready,
	input wire        pslverr,
	input wire        disk_changed_in_n,
	input wire        core_disk_changed_n,
	input wire        write_protect_n,
	input wire        core_write_protect_n,
	input wire        serial1_valid,
	input wire        serial1_access_en,
	input wire        bus_rst_n,
	input wire [3:0]  bus_rst_out_n,
	input wire        supply_power_ok,
	input wire        pok_out_3v,
	input wire        sleep_state5_n,
	input wire        led_yellow_n,
	input wire        led_green_n,
	input wire [7:0]  wake_key_code
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire off_map = paddr[1:0] != 2'h0 || paddr < 8'h80 || paddr > 8'h9C;

	a_zero_wait: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	a_ready_short: assert property (pready |=> !pready)
		else $error("ready held past access cycle");
	a_bad_addr: assert property (psel && !penable && off_map |=> pslverr)
		else $error("unmapped access without error");
	a_change_pin: assert property (!disk_changed_in_n |=> !core_disk_changed_n)
		else $error("disk change input not passed");
	a_protect_pin: assert property (!write_protect_n |=> !core_write_protect_n)
		else $error("protect input not passed");
	a_device_gate: assert property (!serial1_valid |=> !serial1_access_en)
		else $error("access granted without valid");
	a_bus_reset: assert property (!bus_rst_n |=> bus_rst_out_n == 4'h0)
		else $error("reset outputs not low");
	a_pok_drop: assert property (!supply_power_ok |=> !pok_out_3v)
		else $error("power good output held");
	a_sleep_dark: assert property (!sleep_state5_n [*2] |=> led_yellow_n && led_green_n)
		else $error("led lit in deep sleep");
	a_key_load: assert property (psel && penable && pready && pwrite && pstrb[0]
		&& paddr == 8'h98 |=> wake_key_code == $past(pwdata[7:0]))
		else $error("scan code not loaded");
	c_blink: cover property (!led_green_n ##1 led_green_n);
	c_error: cover property (pslverr);
	c_pok: cover property (!pok_out_3v ##1 pok_out_3v);
endmodule // hmr_regs_sva

bind hmr_regs hmr_regs_sva hmr_regs_sva_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .disk_changed_in_n,
	.core_disk_changed_n, .write_protect_n, .core_write_protect_n,
	.serial1_valid, .serial1_access_en, .bus_rst_n, .bus_rst_out_n,
	.supply_power_ok, .pok_out_3v, .sleep_state5_n, .led_yellow_n,
	.led_green_n, .wake_key_code);

// ### test/hmr_host_model.sv
// Host software model: issues byte-wide register accesses over APB.
// Assumes the bank answers with pready; only the bench watchdog ends a wait.
`timescale 1ns/10ps

module hmr_host_model (
	input  wire        pclk,
	output reg         psel,
	output reg         penable,
	output reg         pwrite,
	output reg  [7:0]  paddr,
	output reg  [31:0] pwdata,
	output reg  [3:0]  pstrb,
	input  wire [31:0] prdata,
	input  wire        pready,
	input  wire        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
	end

	task xfer(input w, input [7:0] a, input [7:0] d,
		output [31:0] q, output e);
		begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= {24'h000000, d};
			@(posedge pclk);
			penable <= 1'b1;
			do begin
				@(posedge pclk);
			end while (pready !== 1'b1);
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			// A released bus shows no stale value.
			paddr <= ~a;
			pwdata <= ~pwdata;
			@(posedge pclk);
		end
	endtask
endmodule // hmr_host_model

// ### test/hmr_regs_bench.sv
// Self-checking bench for the runtime register bank.
// Assumes the host model as APB master and short LED_CONTROL and delay counts.
`timescale 1ns/10ps

module hmr_regs_bench;
	reg         pclk, presetn, vcc_rst_n, bus_rst_n, drive_sel0_n;
	reg         drive_sel1_n, step_n, disk_changed_in_n, write_protect_n;
	reg         forced_protect, rate_wr, fifo1_wr, fifo2_wr, parport_valid;
	reg         serial1_valid, serial2_valid, floppy_valid, sleep_state3_n;
	reg         sleep_state5_n, supply_power_ok;
	reg  [7:0]  rate_wdata, fifo1_wdata, fifo2_wdata;
	wire        psel, penable, pwrite, pready, pslverr, core_disk_changed_n;
	wire        core_write_protect_n, parport_access_en, serial1_access_en;
	wire        serial2_access_en, floppy_access_en, led_yellow_n;
	wire        led_green_n, pok_out_3v;
	wire [7:0]  paddr, wake_key_code;
	wire [31:0] pwdata, prdata;
	wire [3:0]  pstrb, bus_rst_out_n;
	int         mismatches, checks;
	reg  [31:0] q;
	reg         e;

	hmr_regs #(.HALF_CYCLES(8), .POK_CYCLES(5)) hmr_regs_i (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .vcc_rst_n, .bus_rst_n, .drive_sel0_n, .drive_sel1_n,
		.step_n, .disk_changed_in_n, .write_protect_n, .forced_protect,
		.core_disk_changed_n, .core_write_protect_n, .rate_wr, .rate_wdata,
		.fifo1_wr, .fifo1_wdata, .fifo2_wr, .fifo2_wdata, .parport_valid,
		.serial1_valid, .serial2_valid, .floppy_valid, .parport_access_en,
		.serial1_access_en, .serial2_access_en, .floppy_access_en,
		.sleep_state3_n, .sleep_state5_n, .supply_power_ok, .led_yellow_n,
		.led_green_n, .wake_key_code, .pok_out_3v, .bus_rst_out_n);
	hmr_host_model hmr_host_model_i (.pclk, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);

	// ****
	// Helpers
	// ****
	task chk(input string what, input [31:0] exp, input [31:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task rd(input [7:0] a, input [31:0] exp);
		hmr_host_model_i.xfer(1'b0, a, 8'h00, q, e);
		chk($sformatf("read %h", a), exp, q);
	endtask
	task wr(input [7:0] a, input [7:0] d);
		hmr_host_model_i.xfer(1'b1, a, d, q, e);
	endtask
	task tally_and_finish;
		if (mismatches == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ****
	// Scenarios
	// ****
	task t_reset_map;
		for (int i = 0; i < 8; i++)
			rd(8'h80 + 8'(4 * i), (i == 7) ? 32'h000000F1 : 32'h0);
		hmr_host_model_i.xfer(1'b1, 8'h81, 8'hFF, q, e);
		chk("slave error", 1, e);
		rd(8'hA0, 32'h0);
	endtask
	task t_shadows;
		{rate_wr, fifo1_wr, fifo2_wr} <= 3'h7;
		{rate_wdata, fifo1_wdata, fifo2_wdata} <= 24'hA55AC3;
		cyc(1);
		{rate_wr, fifo1_wr, fifo2_wr} <= 3'h0;
		cyc(1);
		rd(8'h84, 32'hA5);
		rd(8'h88, 32'h5A);
		rd(8'h8C, 32'hC3);
		wr(8'h84, 8'h00);
		wr(8'h8C, 8'hFF);
		rd(8'h84, 32'hA5);
		rd(8'h8C, 32'hC3);
	endtask
	task t_force;
		wr(8'h80, 8'h01);
		wr(8'h80, 8'h00);
		rd(8'h80, 32'h1);
		drive_sel0_n <= 1'b0;
		cyc(2);
		chk("disk change", 0, core_disk_changed_n);
		drive_sel0_n <= 1'b1;
		cyc(2);
		chk("disk change", 1, core_disk_changed_n);
		disk_changed_in_n <= 1'b0;
		cyc(2);
		chk("disk change", 0, core_disk_changed_n);
		disk_changed_in_n <= 1'b1;
		rd(8'h80, 32'h0);
		wr(8'h80, 8'h01);
		step_n <= 1'b0;
		cyc(1);
		step_n <= 1'b1;
		rd(8'h80, 32'h0);
		wr(8'h80, 8'h01);
		bus_rst_n <= 1'b0;
		cyc(1);
		bus_rst_n <= 1'b1;
		rd(8'h80, 32'h0);
		chk("bus reset out", 4'hF, bus_rst_out_n);
		wr(8'h80, 8'h01);
		vcc_rst_n <= 1'b0;
		cyc(1);
		vcc_rst_n <= 1'b1;
		rd(8'h80, 32'h0);
	endtask
	task t_disable;
		wr(8'h90, 8'hFF);
		rd(8'h90, 32'hE9);
		chk("access", 0, {parport_access_en, serial1_access_en,
			serial2_access_en, floppy_access_en});
		chk("protect", 0, core_write_protect_n);
		wr(8'h90, 8'h00);
		serial1_valid <= 1'b0;
		cyc(2);
		chk("access", 4'hB, {parport_access_en, serial1_access_en,
			serial2_access_en, floppy_access_en});
		chk("protect", 1, core_write_protect_n);
		write_protect_n <= 1'b0;
		cyc(2);
		chk("protect", 0, core_write_protect_n);
		write_protect_n <= 1'b1;
		serial1_valid <= 1'b1;
		forced_protect <= 1'b1;
		cyc(2);
		chk("protect", 1, core_write_protect_n);
		drive_sel1_n <= 1'b0;
		cyc(2);
		chk("protect", 0, core_write_protect_n);
		{forced_protect, drive_sel1_n} <= 2'h1;
	endtask
	task t_led;
		int n;
		wr(8'h94, 8'h0F);
		rd(8'h94, 32'h0F);
		chk("pins", 2'h2, {led_yellow_n, led_green_n});
		wr(8'h94, 8'h03);
		cyc(1);
		chk("pins", 2'h1, {led_yellow_n, led_green_n});
		sleep_state3_n <= 1'b0;
		cyc(2);
		wr(8'h94, 8'h00);
		rd(8'h94, 32'h01);
		n = 0;
		repeat (32) begin
			@(posedge pclk);
			n += (led_green_n === 1'b0);
		end
		chk("lit cycles", 16, n);
		sleep_state5_n <= 1'b0;
		cyc(3);
		chk("pins", 2'h3, {led_yellow_n, led_green_n});
		{sleep_state3_n, sleep_state5_n} <= 2'h3;
		wr(8'h94, 8'h06);
		cyc(1);
		chk("pins", 2'h3, {led_yellow_n, led_green_n});
		wr(8'h94, 8'h0C);
		rd(8'h94, 32'h0C);
		vcc_rst_n <= 1'b0;
		cyc(1);
		vcc_rst_n <= 1'b1;
		rd(8'h94, 32'h00);
	endtask
	task t_key_pok;
		wr(8'h98, 8'h3C);
		rd(8'h98, 32'h3C);
		chk("wake key", 8'h3C, wake_key_code);
		supply_power_ok <= 1'b0;
		cyc(2);
		supply_power_ok <= 1'b1;
		cyc(3);
		chk("pok delayed", 0, pok_out_3v);
		cyc(6);
		chk("pok delayed", 1, pok_out_3v);
		wr(8'h9C, 8'hF0);
		supply_power_ok <= 1'b0;
		cyc(2);
		supply_power_ok <= 1'b1;
		cyc(2);
		chk("pok direct", 1, pok_out_3v);
		wr(8'h9C, 8'hF2);
		wr(8'h9C, 8'h01);
		rd(8'h9C, 32'h02);
		chk("bus reset out", 0, bus_rst_out_n);
		wr(8'h9C, 8'h40);
		rd(8'h9C, 32'h42);
		chk("bus reset out", 4'h1, bus_rst_out_n);
	endtask

	// ****
	// Sequence
	// ****
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		#500000;
		mismatches++;
		tally_and_finish;
	end
	initial begin
		{presetn, rate_wr, fifo1_wr, fifo2_wr, forced_protect} = 5'h0;
		{vcc_rst_n, bus_rst_n, drive_sel0_n, drive_sel1_n, step_n} = 5'h1F;
		{disk_changed_in_n, write_protect_n, sleep_state3_n} = 3'h7;
		{sleep_state5_n, supply_power_ok, parport_valid} = 3'h7;
		{serial1_valid, serial2_valid, floppy_valid} = 3'h7;
		{rate_wdata, fifo1_wdata, fifo2_wdata} = 24'h000000;
		cyc(4);
		presetn <= 1'b1;
		cyc(1);
		t_reset_map;
		t_shadows;
		t_force;
		t_disable;
		t_led;
		t_key_pok;
		tally_and_finish;
	end
endmodule // hmr_regs_bench
